// ---- tb/ebm_top_tb_top.sv ----
// ************************************************************
// block memory testbench
// ************************************************************
module ebm_top_tb_top
    import ebm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] mode = EBM_SINGLE;
    logic [2:0] wsel_a = EBM_W9;
    logic [2:0] wsel_b = EBM_W9;
    logic oreg_a = 1'b0;
    logic oreg_b = 1'b0; // partner expects raw output
    logic ro_lock = 1'b0;
    logic en_a = 1'b0;
    logic we_a = 1'b0;
    logic [ADDR_W-1:0] addr_a = 13'h0000;
    logic [DATA_W-1:0] wdata_a = 18'h00000;
    logic [DATA_W-1:0] rdata_a;
    logic en_b, we_b;
    logic [ADDR_W-1:0] addr_b;
    logic [DATA_W-1:0] wdata_b, rdata_b;
    logic clear_start = 1'b0;
    logic init_load = 1'b0;
    logic init_we = 1'b0;
    logic [INIT_AW-1:0] init_addr = 9'h000;
    logic [DATA_W-1:0] init_data = 18'h00000;
    logic init_busy;
    int n_fail = 0;
    int checks = 0;
    logic [DATA_W-1:0] d = 18'h3C5A9; // pattern for width matching

    always #5 clk = ~clk;

    ebm_top uut (.clk(clk), .resetn(resetn), .mode(mode),
        .wsel_a(wsel_a), .wsel_b(wsel_b), .oreg_a(oreg_a),
        .oreg_b(oreg_b), .ro_lock(ro_lock), .en_a(en_a), .we_a(we_a),
        .addr_a(addr_a), .wdata_a(wdata_a), .rdata_a(rdata_a),
        .en_b(en_b), .we_b(we_b), .addr_b(addr_b), .wdata_b(wdata_b),
        .rdata_b(rdata_b), .clear_start(clear_start),
        .init_load(init_load), .init_we(init_we), .init_addr(init_addr),
        .init_data(init_data), .init_busy(init_busy));

    ebm_user_b ub (.clk(clk), .en_b(en_b), .we_b(we_b), .addr_b(addr_b),
        .wdata_b(wdata_b));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp,
        input string msg);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    // one write on port a, then a spare cycle for it to land
    task automatic wr_a(input logic [12:0] a, input logic [17:0] v);
        @(negedge clk);
        {en_a, we_a, addr_a, wdata_a} = {2'b11, a, v};
        @(negedge clk);
        {en_a, we_a} = 2'b00;
        @(negedge clk);
    endtask : wr_a

    // one read on port a, judged on the cycle the answer is due
    task automatic rd_a(input logic [12:0] a, input logic [17:0] exp);
        @(negedge clk);
        {en_a, we_a, addr_a} = {2'b10, a};
        @(negedge clk);
        en_a = 1'b0;
        @(negedge clk);
        chk(rdata_a, exp, "port a read");
    endtask : rd_a

    // one read on port b through the fabric model
    task automatic rd_b(input logic [12:0] a, input logic [17:0] exp);
        ub.rd(a);
        @(negedge clk);
        @(negedge clk);
        chk(rdata_b, exp, "port b read");
    endtask : rd_b

    // ************************************************************
    // scenarios
    // ************************************************************
    // zero fill: busy count, then word 1 reads back zero
    task automatic t_clear();
        int n;
        n = 0;
        @(negedge clk);
        clear_start = 1'b1;
        @(negedge clk);
        clear_start = 1'b0;
        while (init_busy === 1'b1 && n < 600) begin
            n++;
            @(negedge clk);
        end
        if (n >= 600) begin
            n_fail++;
            end_sim();
        end
        chk(18'(n), 18'h00200, "fill length");
        rd_a(13'h0001, 18'h00000);
    endtask : t_clear

    // top bit of the deepest shape lands in word 910 bit 1
    task automatic t_depth();
        wsel_a = EBM_W1;
        wr_a(13'h1FFF, 18'h00001);
        wsel_a = EBM_W9;
        rd_a(13'h038E, 18'h00002);
        wsel_a = EBM_W18; // outside pseudo dual this must act as 9
        rd_a(13'h038E, 18'h00002);
        wsel_a = EBM_W9;
    endtask : t_depth

    // back-to-back reads, raw and registered; off by one shows
    task automatic t_latency();
        wr_a(13'h0005, 18'h00155);
        wr_a(13'h0006, 18'h000AA);
        for (int o = 0; o < 2; o++) begin
            oreg_a = o[0];
            @(negedge clk);
            {en_a, we_a, addr_a} = {2'b10, 13'h0005};
            @(negedge clk);
            addr_a = 13'h0006;
            @(negedge clk);
            en_a = 1'b0;
            repeat (o) @(negedge clk);
            chk(rdata_a, 18'h00155, "first read");
            @(negedge clk);
            chk(rdata_a, 18'h000AA, "second read");
        end
        oreg_a = 1'b0;
    endtask : t_latency

    // wide write on a, narrow reads on b over the same bits
    task automatic t_match();
        mode = EBM_PSEUDO_DP;
        {wsel_a, wsel_b} = {EBM_W18, EBM_W1};
        wr_a(13'h0000, d);
        for (int i = 0; i < 18; i++) begin
            rd_b(13'(i), {17'h00000, d[i]});
        end
        wsel_b = EBM_W9;
        rd_b(13'h0001, {9'h000, d[17:9]});
        wsel_b = EBM_W18;
        rd_b(13'h0000, d);
        {mode, wsel_a} = {EBM_SINGLE, EBM_W9};
    endtask : t_match

    // true dual: narrow reads on b, 18 acts as 9, b dead in single
    task automatic t_dual();
        mode = EBM_TRUE_DP;
        wr_a(13'h0001, 18'h000A5);
        wsel_b = EBM_W2;
        rd_b(13'h0005, 18'h00002);
        wsel_b = EBM_W18; // outside pseudo dual this must act as 9
        rd_b(13'h0001, 18'h000A5);
        mode = EBM_SINGLE;
        // a read on a dead port b leaves the last word standing
        rd_b(13'h0000, 18'h000A5);
    endtask : t_dual

    // preload two flash words, then use as rom with writes locked
    task automatic t_rom();
        @(negedge clk);
        init_load = 1'b1;
        @(negedge clk);
        chk({17'h00000, init_busy}, 18'h00001, "load busy");
        {init_we, init_addr, init_data} = {1'b1, 9'h000, 18'h2A5C3};
        @(negedge clk);
        {init_addr, init_data} = {9'h001, 18'h15A3C};
        @(negedge clk);
        {init_we, init_load} = 2'b00;
        @(negedge clk);
        chk({17'h00000, init_busy}, 18'h00000, "load end");
        ro_lock = 1'b1;
        wr_a(13'h0000, 18'h001FF);
        rd_a(13'h0000, 18'h001C3);
        rd_a(13'h0002, 18'h0003C);
        ro_lock = 1'b0;
    endtask : t_rom

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_clear();
        t_depth();
        t_latency();
        t_match();
        t_dual();
        t_rom();
        end_sim();
    end
endmodule : ebm_top_tb_top

// ---- tb/ebm_user_b.sv ----
// ************************************************************
// fabric user logic on port b
// ************************************************************
module ebm_user_b
    import ebm_pkg::*;
(
    input wire logic clk,
    output logic en_b,
    output logic we_b,
    output logic [ADDR_W-1:0] addr_b,
    output logic [DATA_W-1:0] wdata_b
);
    timeunit 1ns;
    timeprecision 100ps;

    logic req = 1'b0; // read wanted this cycle
    logic [ADDR_W-1:0] req_addr = 13'h0000; // address of that read

    // lines move only after the falling edge; a stale address wanders
    // so it differs from the one asked for on every other idle cycle
    // one process owns every line, so each has a single driver
    initial begin
        en_b = 1'b0;
        we_b = 1'b0; // writes stay off for good
        addr_b = 13'h0000;
        wdata_b = 18'h00000;
        forever begin
            @(negedge clk);
            en_b <= req;
            addr_b <= req ? req_addr : ~addr_b;
            wdata_b <= ~wdata_b; // never written
        end
    end

    // one read; req is touched only on the rising edge
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        req_addr = a;
        req = 1'b1;
        @(posedge clk);
        req = 1'b0;
    endtask : rd
endmodule : ebm_user_b

// ---- verilog/ebm_pkg.sv ----
// ************************************************************
// block memory shared constants
// ************************************************************
package ebm_pkg;
    localparam int MEM_BITS = 9216;     // one block: 1024 x 9 bits
    localparam int ADDR_W = 13;         // enough for 8192 x 1
    localparam int DATA_W = 18;         // widest port, 512 x 18
    localparam int BASE_W = 14;         // bit index into the array
    localparam int INIT_WORDS = 512;    // flash words of 18 bits
    localparam int INIT_AW = 9;         // flash word index width
    localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [INIT_AW-1:0] CNT_RST = 9'h000;
    localparam logic [INIT_AW-1:0] CNT_LAST = 9'h1FF;

    // port width codes
    typedef enum logic [2:0] {
        EBM_W1 = 3'h0,
        EBM_W2 = 3'h1,
        EBM_W4 = 3'h2,
        EBM_W9 = 3'h3,
        EBM_W18 = 3'h4
    } ebm_width_t;

    // memory arrangement
    typedef enum logic [1:0] {
        EBM_SINGLE = 2'h0,   // port a only
        EBM_TRUE_DP = 2'h1,  // both ports read and write
        EBM_PSEUDO_DP = 2'h2 // port a writes, port b reads
    } ebm_mode_t;

    // initialisation sequencer, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CLEAR = 3'h2,
        ST_LOAD = 3'h4
    } ebm_init_t;
endpackage : ebm_pkg

// ---- verilog/ebm_port.sv ----
// ************************************************************
// one port: input capture and optional output stage
// ************************************************************
module ebm_port
    import ebm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic oreg,
    output logic [DATA_W-1:0] rdata,
    ebm_port_if.port arr
);
    logic en_q;                 // a read is at the array
    logic en_d;                 // that read sits in stage
    logic [DATA_W-1:0] stage;   // optional output stage

    // capture address, data and strobes at the array input
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arr.addr_q <= ADDR_RST;
            arr.wdata_q <= DATA_RST;
            arr.we_q <= 1'b0;
            en_q <= 1'b0;
        end else if (arr.hold) begin
            // ports are dead while the array is initialised
            arr.we_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            arr.addr_q <= addr;
            arr.wdata_q <= wdata;
            arr.we_q <= en & we;
            en_q <= en;
        end
    end

    // extra stage for the registered output choice
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stage <= DATA_RST;
            en_d <= 1'b0;
        end else begin
            en_d <= en_q;
            if (en_q) begin
                stage <= arr.arr_rd;
            end
        end
    end

    // read data holds until the next read lands
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata <= DATA_RST;
        end else if (oreg) begin
            if (en_d) begin
                rdata <= stage;
            end
        end else if (en_q) begin
            rdata <= arr.arr_rd;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    property p_capture;
        @(posedge clk) disable iff (!resetn)
        (!arr.hold && en) |=> (arr.addr_q == $past(addr));
    endproperty
    a_capture: assert property (p_capture)
        else $error("address not captured at port input");

    property p_direct;
        @(posedge clk) disable iff (!resetn)
        (!oreg && en_q) |=> (rdata == $past(arr.arr_rd));
    endproperty
    a_direct: assert property (p_direct)
        else $error("unregistered read not one clock late");

    property p_staged;
        @(posedge clk) disable iff (!resetn)
        (oreg && en_q) ##1 oreg |=> (rdata == $past(arr.arr_rd, 2));
    endproperty
    a_staged: assert property (p_staged)
        else $error("registered read not two clocks late");
endmodule : ebm_port

// ---- verilog/ebm_port_if.sv ----
// ************************************************************
// array side of one user port
// ************************************************************
interface ebm_port_if;
    import ebm_pkg::*;
    logic [ADDR_W-1:0] addr_q;  // captured address
    logic [DATA_W-1:0] wdata_q; // captured write data
    logic we_q;                 // captured write strobe
    logic [DATA_W-1:0] arr_rd;  // array read word
    logic hold;                 // port held off: array busy with init, or port b in single mode
    modport port (output addr_q, wdata_q, we_q, input arr_rd, hold);
    modport core (input addr_q, wdata_q, we_q, output arr_rd, hold);
endinterface : ebm_port_if

// ---- verilog/ebm_top.sv ----
module ebm_top
    import ebm_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] mode,
    input wire logic [2:0] wsel_a,
    input wire logic [2:0] wsel_b,
    input wire logic oreg_a,
    input wire logic oreg_b,
    input wire logic ro_lock,
    input wire logic en_a,
    input wire logic we_a,
    input wire logic [ADDR_W-1:0] addr_a,
    input wire logic [DATA_W-1:0] wdata_a,
    output logic [DATA_W-1:0] rdata_a,
    input wire logic en_b,
    input wire logic we_b,
    input wire logic [ADDR_W-1:0] addr_b,
    input wire logic [DATA_W-1:0] wdata_b,
    output logic [DATA_W-1:0] rdata_b,
    input wire logic clear_start,
    input wire logic init_load,
    input wire logic init_we,
    input wire logic [INIT_AW-1:0] init_addr,
    input wire logic [DATA_W-1:0] init_data,
    output logic init_busy
);
    // ********************************************************
    // storage and port plumbing
    // ********************************************************
    logic mem [0:MEM_BITS-1];   // flat bit array, not reset
    ebm_init_t state;           // init sequencer state
    ebm_init_t next_state;      // its next value
    logic [INIT_AW-1:0] cnt;    // clear word counter
    logic [4:0] w_a;            // port a width in bits
    logic [4:0] w_b;            // port b width in bits
    logic [BASE_W-1:0] base_a;  // first bit of port a word
    logic [BASE_W-1:0] base_b;  // first bit of port b word
    logic wr_a;                 // port a writes this cycle
    logic wr_b;                 // port b writes this cycle
    localparam int CLR_CYC = INIT_WORDS;

    ebm_port_if pa ();
    ebm_port_if pb ();

    // turn a width code into a bit count
    function automatic logic [4:0] width_of(
        input logic [2:0] code,
        input logic wide_ok
    );
        logic [4:0] w;
        w = 5'h09;
        case (code)
            EBM_W1: w = 5'h01;
            EBM_W2: w = 5'h02;
            EBM_W4: w = 5'h04;
            EBM_W9: w = 5'h09;
            // 18 bits only where the mode allows it
            EBM_W18: w = wide_ok ? 5'h12 : 5'h09;
            default: w = 5'h09;
        endcase
        return w;
    endfunction : width_of

    // word address to first bit; address is masked to depth
    function automatic logic [BASE_W-1:0] base_of(
        input logic [ADDR_W-1:0] a,
        input logic [4:0] w
    );
        logic [ADDR_W-1:0] m;
        logic [17:0] p;
        m = a;
        case (w)
            5'h02: m = {1'b0, a[11:0]};
            5'h04: m = {2'h0, a[10:0]};
            5'h09: m = {3'h0, a[9:0]};
            5'h12: m = {4'h0, a[8:0]};
            default: m = a;
        endcase
        p = 18'(m) * 18'(w);
        return p[BASE_W-1:0];
    endfunction : base_of

    // each port decodes its own width, so a and b may differ
    assign w_a = width_of(wsel_a, mode == EBM_PSEUDO_DP);
    assign w_b = width_of(wsel_b, mode == EBM_PSEUDO_DP);
    assign base_a = base_of(pa.addr_q, w_a);
    assign base_b = base_of(pb.addr_q, w_b);

    // read-only use: the lock also blocks any stray strobe
    assign wr_a = pa.we_q && !ro_lock;
    assign wr_b = pb.we_q && !ro_lock && mode == EBM_TRUE_DP;

    // ports stall for the whole of an init sequence
    assign pa.hold = state != ST_IDLE;
    assign pb.hold = (state != ST_IDLE) || (mode == EBM_SINGLE);

    // ********************************************************
    // user ports
    // ********************************************************
    ebm_port u_port_a (
        .clk(clk),
        .resetn(resetn),
        .en(en_a),
        .we(we_a),
        .addr(addr_a),
        .wdata(wdata_a),
        .oreg(oreg_a),
        .rdata(rdata_a),
        .arr(pa.port)
    );

    ebm_port u_port_b (
        .clk(clk),
        .resetn(resetn),
        .en(en_b),
        .we(we_b),
        .addr(addr_b),
        .wdata(wdata_b),
        .oreg(oreg_b),
        .rdata(rdata_b),
        .arr(pb.port)
    );

    // read both ports from the same bit order
    always_comb begin
        pa.arr_rd = DATA_RST;
        pb.arr_rd = DATA_RST;
        for (int i = 0; i < DATA_W; i++) begin
            if (i < int'(w_a) && int'(base_a) + i < MEM_BITS) begin
                pa.arr_rd[i] = mem[int'(base_a) + i];
            end
            if (i < int'(w_b) && int'(base_b) + i < MEM_BITS) begin
                pb.arr_rd[i] = mem[int'(base_b) + i];
            end
        end
    end

    // ********************************************************
    // array writes
    // ********************************************************
    // init first, then b, then a per bit index: a wins a same-bit collision unless b's word starts lower
    always_ff @(posedge clk) begin
        for (int i = 0; i < DATA_W; i++) begin
            if (state == ST_CLEAR) begin
                // zero fill is generated here, no flash read
                mem[int'(cnt) * DATA_W + i] <= 1'b0;
            end else if (state == ST_LOAD && init_we) begin
                mem[int'(init_addr) * DATA_W + i] <= init_data[i];
            end else begin
                if (wr_b && i < int'(w_b)
                        && int'(base_b) + i < MEM_BITS) begin
                    mem[int'(base_b) + i] <= pb.wdata_q[i];
                end
                if (wr_a && i < int'(w_a)
                        && int'(base_a) + i < MEM_BITS) begin
                    mem[int'(base_a) + i] <= pa.wdata_q[i];
                end
            end
        end
    end

    // ********************************************************
    // initialisation sequencer
    // ********************************************************
    // pick the next init state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (clear_start) begin
                    next_state = ST_CLEAR;
                end else if (init_load) begin
                    next_state = ST_LOAD;
                end
            end
            ST_CLEAR: begin
                if (cnt == CNT_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            // load stream carries only word indices, so one
            // flash region can feed several blocks at once
            ST_LOAD: begin
                if (!init_load) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // state and busy flag
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            init_busy <= 1'b0;
        end else begin
            state <= next_state;
            init_busy <= next_state != ST_IDLE;
        end
    end

    // clear counter walks every flash word slot once
    always_ff @(posedge clk) begin
        if (!resetn || state != ST_CLEAR) begin
            cnt <= CNT_RST;
        end else begin
            cnt <= cnt + 9'h001;
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    property p_wide_mode;
        @(posedge clk) disable iff (!resetn)
        (mode != EBM_PSEUDO_DP) |-> (w_a != 5'h12 && w_b != 5'h12);
    endproperty
    a_wide_mode: assert property (p_wide_mode)
        else $error("18-bit port outside pseudo dual port");

    property p_bit_order;
        @(posedge clk) disable iff (!resetn)
        (wr_a && state == ST_IDLE)
            |=> (mem[$past(base_a)] == $past(pa.wdata_q[0]));
    endproperty
    a_bit_order: assert property (p_bit_order)
        else $error("port a lsb not at first bit of word");

    property p_load;
        @(posedge clk) disable iff (!resetn)
        (state == ST_LOAD && init_we)
            |=> (mem[int'($past(init_addr)) * DATA_W]
                 == $past(init_data[0]));
    endproperty
    a_load: assert property (p_load)
        else $error("flash word not loaded into array");

    property p_clear;
        @(posedge clk) disable iff (!resetn)
        (state == ST_IDLE && clear_start)
            |=> (state == ST_CLEAR) ##[CLR_CYC:CLR_CYC] (state == ST_IDLE);
    endproperty
    a_clear: assert property (p_clear)
        else $error("zero fill length wrong");

    // a locked strobe must leave the addressed bit as it was
    property p_ro_lock;
        @(posedge clk) disable iff (!resetn)
        (ro_lock && pa.we_q && state == ST_IDLE)
            |=> (mem[$past(base_a)] == $past(mem[base_a]));
    endproperty
    a_ro_lock: assert property (p_ro_lock)
        else $error("write reached array while locked");

    property p_busy;
        @(posedge clk) disable iff (!resetn)
        (state == ST_IDLE && init_load && !clear_start)
            |=> (init_busy && state == ST_LOAD);
    endproperty
    a_busy: assert property (p_busy)
        else $error("load did not start");
endmodule : ebm_top
